// ---- design/mcru_regs.vh ----
`ifndef MCRU_REGS_VH
`define MCRU_REGS_VH
// Behaviour
// RL1: operands latched only on their clock bit
// RL2: new operands and result every cycle
// RL3: wide product or two 16-bit products
// RL4: signed 16x16 multiply to 32 bits
// RL5: unsigned 16x16 multiply to 32 bits
// RL6: four byte pairings, first to upper port
// RL7: operand bytes are unsigned 8-bit values
// RL8: ones count in low five bits
// RL9: count first, second, or both operands
// RL10: mirror first operand onto upper port
// RL11: leading one index in low four bits
// RL12: all-zero input gives value sixteen
// RL13: leading one index: second operand, lower port
// RL14: count and pass combinations per port
// RL15: pass first with second counted
// RL16: mirror first with second passed or counted
// RL17: load lower, upper, or both comparands
// RL18: equality flags per port against comparand
// RL19: unsigned greater-than flags per port
// RL20: port most significant bits as flags
// RL21: control picks one opcode, clocks when needed
// RL22: uncounted ports carry their named operand

// =====================================
// operation codes
`define MCRU_OP_W 5
`define MCRU_OP_PASS 5'h00
`define MCRU_OP_SMUL 5'h01
`define MCRU_OP_UMUL 5'h02
`define MCRU_OP_HM_UU_LL 5'h03
`define MCRU_OP_HM_UL_LU 5'h04
`define MCRU_OP_HM_LU_UL 5'h05
`define MCRU_OP_HM_LL_UU 5'h06
`define MCRU_OP_PC_PC 5'h07
`define MCRU_OP_RV_SC 5'h08
`define MCRU_OP_PC_PASS 5'h09
`define MCRU_OP_PC_SC 5'h0A
`define MCRU_OP_PASS_PC 5'h0B
`define MCRU_OP_PASS_SC 5'h0C
`define MCRU_OP_RV_PASS 5'h0D
`define MCRU_OP_RV_PC 5'h0E
`define MCRU_OP_LOAD_CL 5'h0F
`define MCRU_OP_LOAD_CH 5'h10
`define MCRU_OP_LOAD_CLCH 5'h11

// =====================================
// register byte offsets
`define MCRU_STATUS_OFS 8'h00
`define MCRU_RESULT_OFS 8'h04
`define MCRU_COMPARE_OFS 8'h08
`define MCRU_OPERAND_OFS 8'h0C

// =====================================
// status field positions
`define MCRU_ST_UPPER_EQ 0
`define MCRU_ST_LOWER_EQ 1
`define MCRU_ST_UPPER_GT 2
`define MCRU_ST_LOWER_GT 3
`define MCRU_ST_UPPER_MSB 4
`define MCRU_ST_LOWER_MSB 5
`define MCRU_ST_W 6

// =====================================
// reset values
`define MCRU_WORD_RST 16'h0000
`define MCRU_STATUS_RST 6'h00
`define MCRU_ZERO_INDEX 5'h10
`endif

// ---- design/mcru_byte_mul.v ----
// =====================================
// unsigned 8 by 8 multiplier
module mcru_byte_mul
(
   // operands
   input wire [7:0] mul_a,
   input wire [7:0] mul_b,
   // product
   output wire [15:0] mul_p
);

   assign mul_p = {8'h00, mul_a} * {8'h00, mul_b}; // [RL7]

endmodule // mcru_byte_mul

// ---- design/mcru_word_count.v ----
`include "mcru_regs.vh"
// =====================================
// ones count and leading one index of a word
module mcru_word_count
#(
   parameter WIDTH = 16
)
(
   // word
   input wire [WIDTH-1:0] word_in,
   // counts
   output reg [4:0] ones_count,
   output reg [4:0] leading_one_index
);

   integer i;

   always @*
   begin
      ones_count = 5'h00;
      leading_one_index = `MCRU_ZERO_INDEX; // [RL12]
      for (i = 0; i < WIDTH; i = i + 1)
      begin
         ones_count = ones_count + {4'h0, word_in[i]}; // [RL8]
         if (word_in[i])
         begin
            leading_one_index = i[4:0]; // [RL11]
         end
      end
   end

endmodule // mcru_word_count

// ---- design/mcru_unit.v ----
`include "mcru_regs.vh"
// =====================================
// multiply, count and reverse functional unit
module mcru_unit
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // crossbar inputs
   input wire [15:0] crossbar_in_first,
   input wire [15:0] crossbar_in_second,
   // microinstruction control
   input wire clock_a_bit,
   input wire clock_b_bit,
   input wire [4:0] op_sel,
   // results
   output wire [15:0] upper_result,
   output wire [15:0] lower_result,
   // status flags
   output wire upper_eq_flag,
   output wire lower_eq_flag,
   output wire upper_gt_flag,
   output wire lower_gt_flag,
   output wire upper_msb_flag,
   output wire lower_msb_flag,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata
);

   // =====================================
   // state
   reg [15:0] opa_reg;
   reg [15:0] opb_reg;
   reg [15:0] upper_comparand_reg;
   reg [15:0] lower_comparand_reg;
   reg [15:0] upper_reg;
   reg [15:0] lower_reg;
   reg [`MCRU_ST_W-1:0] status_reg;
   reg [31:0] hrdata_reg;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;

   reg [15:0] upper_next;
   reg [15:0] lower_next;
   reg hold_result;
   reg [15:0] upper_comparand_next;
   reg [15:0] lower_comparand_next;
   reg [31:0] rd_next;

   wire [7:0] opa_high_byte;
   wire [7:0] opa_low_byte;
   wire [7:0] opb_high_byte;
   wire [7:0] opb_low_byte;
   wire [31:0] wide_product_signed;
   wire [31:0] wide_product_unsigned;
   wire [15:0] byte_prod_first;
   wire [15:0] byte_prod_second;
   reg [7:0] mul_first_a;
   reg [7:0] mul_first_b;
   reg [7:0] mul_second_a;
   reg [7:0] mul_second_b;
   wire [4:0] ones_count_a;
   wire [4:0] ones_count_b;
   wire [4:0] leading_one_index_b;
   wire [15:0] bit_mirror_a;
   wire [`MCRU_ST_W-1:0] status_next;
   wire addr_phase;
   wire ahb_wr;

   // =====================================
   // functions
   function [15:0] mirror16;
      input [15:0] w;
      integer k;
      begin
         for (k = 0; k < 16; k = k + 1)
         begin
            mirror16[15 - k] = w[k];
         end
      end
   endfunction

   function [15:0] widen5;
      input [4:0] c;
      begin
         widen5 = {11'h000, c};
      end
   endfunction

   // =====================================
   // operand registers
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         opa_reg <= `MCRU_WORD_RST;
         opb_reg <= `MCRU_WORD_RST;
      end
      else
      begin
         if (clock_a_bit)
         begin
            opa_reg <= crossbar_in_first; // [RL1] [RL21]
         end
         if (clock_b_bit)
         begin
            opb_reg <= crossbar_in_second; // [RL1]
         end
      end
   end

   assign opa_high_byte = opa_reg[15:8]; // [RL7]
   assign opa_low_byte = opa_reg[7:0];
   assign opb_high_byte = opb_reg[15:8];
   assign opb_low_byte = opb_reg[7:0];

   // =====================================
   // arithmetic sections
   assign wide_product_signed = $signed(opa_reg) * $signed(opb_reg); // [RL4]
   assign wide_product_unsigned = opa_reg * opb_reg; // [RL5]
   assign bit_mirror_a = mirror16(opa_reg); // [RL10]

   // byte pairings, first product feeds the upper port
   always @*
   begin
      mul_first_a = opa_high_byte;
      mul_first_b = opb_high_byte;
      mul_second_a = opa_low_byte;
      mul_second_b = opb_low_byte;
      case (op_sel)
         `MCRU_OP_HM_UL_LU:
         begin
            mul_first_b = opb_low_byte; // [RL6]
            mul_second_b = opb_high_byte;
         end
         `MCRU_OP_HM_LU_UL:
         begin
            mul_first_a = opa_low_byte; // [RL6]
            mul_second_a = opa_high_byte;
            mul_second_b = opb_low_byte;
         end
         `MCRU_OP_HM_LL_UU:
         begin
            mul_first_a = opa_low_byte; // [RL6]
            mul_first_b = opb_low_byte;
            mul_second_a = opa_high_byte;
            mul_second_b = opb_high_byte;
         end
         default:
         begin
            mul_first_a = opa_high_byte;
         end
      endcase
   end

   mcru_byte_mul u_mul_first
   (
      .mul_a(mul_first_a),
      .mul_b(mul_first_b),
      .mul_p(byte_prod_first)
   );

   mcru_byte_mul u_mul_second
   (
      .mul_a(mul_second_a),
      .mul_b(mul_second_b),
      .mul_p(byte_prod_second)
   );

   mcru_word_count #(.WIDTH(16)) u_count_a
   (
      .word_in(opa_reg),
      .ones_count(ones_count_a),
      .leading_one_index()
   );

   mcru_word_count #(.WIDTH(16)) u_count_b
   (
      .word_in(opb_reg),
      .ones_count(ones_count_b),
      .leading_one_index(leading_one_index_b)
   );

   // =====================================
   // result selection
   always @*
   begin
      upper_next = opa_reg; // [RL22]
      lower_next = opb_reg; // [RL22]
      hold_result = 1'b0;
      case (op_sel)
         `MCRU_OP_PASS:
         begin
            upper_next = opa_reg; // [RL14]
            lower_next = opb_reg;
         end
         `MCRU_OP_SMUL:
         begin
            upper_next = wide_product_signed[31:16]; // [RL3] [RL4]
            lower_next = wide_product_signed[15:0];
         end
         `MCRU_OP_UMUL:
         begin
            upper_next = wide_product_unsigned[31:16]; // [RL3] [RL5]
            lower_next = wide_product_unsigned[15:0];
         end
         `MCRU_OP_HM_UU_LL, `MCRU_OP_HM_UL_LU, `MCRU_OP_HM_LU_UL, `MCRU_OP_HM_LL_UU:
         begin
            upper_next = byte_prod_first; // [RL3] [RL6]
            lower_next = byte_prod_second;
         end
         `MCRU_OP_PC_PC:
         begin
            upper_next = widen5(ones_count_a); // [RL8] [RL9]
            lower_next = widen5(ones_count_b);
         end
         `MCRU_OP_RV_SC:
         begin
            upper_next = bit_mirror_a; // [RL16]
            lower_next = widen5(leading_one_index_b); // [RL13]
         end
         `MCRU_OP_PC_PASS:
         begin
            upper_next = widen5(ones_count_a); // [RL9] [RL14]
            lower_next = opb_reg;
         end
         `MCRU_OP_PC_SC:
         begin
            upper_next = widen5(ones_count_a); // [RL14]
            lower_next = widen5(leading_one_index_b); // [RL13]
         end
         `MCRU_OP_PASS_PC:
         begin
            upper_next = opa_reg; // [RL9] [RL15]
            lower_next = widen5(ones_count_b);
         end
         `MCRU_OP_PASS_SC:
         begin
            upper_next = opa_reg; // [RL15]
            lower_next = widen5(leading_one_index_b); // [RL13]
         end
         `MCRU_OP_RV_PASS:
         begin
            upper_next = bit_mirror_a; // [RL16]
            lower_next = opb_reg;
         end
         `MCRU_OP_RV_PC:
         begin
            upper_next = bit_mirror_a; // [RL16]
            lower_next = widen5(ones_count_b);
         end
         `MCRU_OP_LOAD_CL, `MCRU_OP_LOAD_CH, `MCRU_OP_LOAD_CLCH:
         begin
            hold_result = 1'b1;
         end
         default:
         begin
            hold_result = 1'b1;
         end
      endcase
   end

   // =====================================
   // result and status registers, one result per cycle
   assign status_next[`MCRU_ST_UPPER_EQ] = (upper_next == upper_comparand_reg); // [RL18]
   assign status_next[`MCRU_ST_LOWER_EQ] = (lower_next == lower_comparand_reg); // [RL18]
   assign status_next[`MCRU_ST_UPPER_GT] = (upper_next > upper_comparand_reg); // [RL19]
   assign status_next[`MCRU_ST_LOWER_GT] = (lower_next > lower_comparand_reg); // [RL19]
   assign status_next[`MCRU_ST_UPPER_MSB] = upper_next[15]; // [RL20]
   assign status_next[`MCRU_ST_LOWER_MSB] = lower_next[15]; // [RL20]

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         upper_reg <= `MCRU_WORD_RST;
         lower_reg <= `MCRU_WORD_RST;
         status_reg <= `MCRU_STATUS_RST;
      end
      else if (!hold_result)
      begin
         upper_reg <= upper_next; // [RL2]
         lower_reg <= lower_next;
         status_reg <= status_next;
      end
   end

   assign upper_result = upper_reg;
   assign lower_result = lower_reg;
   assign upper_eq_flag = status_reg[`MCRU_ST_UPPER_EQ];
   assign lower_eq_flag = status_reg[`MCRU_ST_LOWER_EQ];
   assign upper_gt_flag = status_reg[`MCRU_ST_UPPER_GT];
   assign lower_gt_flag = status_reg[`MCRU_ST_LOWER_GT];
   assign upper_msb_flag = status_reg[`MCRU_ST_UPPER_MSB];
   assign lower_msb_flag = status_reg[`MCRU_ST_LOWER_MSB];

   // =====================================
   // ahb-lite slave, zero wait states
   assign addr_phase = hsel & htrans[1] & hready;
   assign ahb_wr = wr_pend_reg & (wr_addr_reg == `MCRU_COMPARE_OFS);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   // comparand loads; the microinstruction wins over a bus write
   always @*
   begin
      upper_comparand_next = upper_comparand_reg;
      lower_comparand_next = lower_comparand_reg;
      if (ahb_wr)
      begin
         upper_comparand_next = hwdata[31:16];
         lower_comparand_next = hwdata[15:0];
      end
      if (op_sel == `MCRU_OP_LOAD_CL || op_sel == `MCRU_OP_LOAD_CLCH)
      begin
         lower_comparand_next = crossbar_in_second; // [RL17]
      end
      if (op_sel == `MCRU_OP_LOAD_CH || op_sel == `MCRU_OP_LOAD_CLCH)
      begin
         upper_comparand_next = crossbar_in_first; // [RL17]
      end
   end

   // read data captured at the address phase
   always @*
   begin
      case (haddr[7:0])
         `MCRU_STATUS_OFS: rd_next = {26'h0000000, status_reg};
         `MCRU_RESULT_OFS: rd_next = {upper_reg, lower_reg};
         `MCRU_COMPARE_OFS: rd_next = {upper_comparand_next, lower_comparand_next};
         `MCRU_OPERAND_OFS: rd_next = {opa_reg, opb_reg};
         default: rd_next = 32'h00000000;
      endcase
      if (haddr[31:8] != 24'h000000)
      begin
         rd_next = 32'h00000000;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         upper_comparand_reg <= `MCRU_WORD_RST;
         lower_comparand_reg <= `MCRU_WORD_RST;
         hrdata_reg <= 32'h00000000;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end
      else
      begin
         upper_comparand_reg <= upper_comparand_next;
         lower_comparand_reg <= lower_comparand_next;
         if (hready)
         begin
            wr_pend_reg <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
            wr_addr_reg <= haddr[7:0];
         end
         if (addr_phase & !hwrite)
         begin
            hrdata_reg <= rd_next;
         end
      end
   end

endmodule // mcru_unit

// ---- tb/mcru_unit_props.sv ----
`include "mcru_regs.vh"
// =====================================
// checker on the unit's ports
module mcru_props
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // control
   input wire [15:0] crossbar_in_first,
   input wire [15:0] crossbar_in_second,
   input wire clock_a_bit,
   input wire clock_b_bit,
   input wire [4:0] op_sel,
   // results and flags
   input wire [15:0] upper_result,
   input wire [15:0] lower_result,
   input wire upper_eq_flag,
   input wire lower_eq_flag,
   input wire upper_gt_flag,
   input wire lower_gt_flag,
   input wire upper_msb_flag,
   input wire lower_msb_flag,
   // bus writes to the comparands
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] opa_q, opb_q, cmp_hi, cmp_lo;
   logic wr_q;
   logic signed [31:0] prod_s;
   wire [15:0] mul_ul = opa_q[15:8] * opb_q[7:0];
   wire [15:0] mul_lu = opa_q[7:0] * opb_q[15:8];
   wire [15:0] ones_a = 16'($countones(opa_q));
   wire [15:0] mir_a = {<<{opa_q}};
   logic [15:0] lead_b;
   assign prod_s = $signed(opa_q) * $signed(opb_q);
   always_comb
   begin
      lead_b = 16'h0010;
      for (int i = 0; i < 16; i++)
         if (opb_q[i]) lead_b = 16'(i);
   end
   // =====================================
   // shadow of operands and comparands
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         opa_q <= 16'h0000;
         opb_q <= 16'h0000;
         cmp_hi <= 16'h0000;
         cmp_lo <= 16'h0000;
         wr_q <= 1'b0;
      end
      else
      begin
         if (clock_a_bit) opa_q <= crossbar_in_first;
         if (clock_b_bit) opb_q <= crossbar_in_second;
         wr_q <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_0008;
         if (wr_q) {cmp_hi, cmp_lo} <= hwdata;
         if (op_sel == `MCRU_OP_LOAD_CH || op_sel == `MCRU_OP_LOAD_CLCH) cmp_hi <= crossbar_in_first;
         if (op_sel == `MCRU_OP_LOAD_CL || op_sel == `MCRU_OP_LOAD_CLCH) cmp_lo <= crossbar_in_second;
      end
   // =====================================
   // assertions
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_valid_op;
      op_sel <= `MCRU_OP_RV_PC;
   endsequence
   AST_MSB: assert property (upper_msb_flag == upper_result[15] && lower_msb_flag == lower_result[15])
      else $error("msb flags disagree with results");
   AST_EQ: assert property (s_valid_op |=> upper_eq_flag == (upper_result == $past(cmp_hi))
      && lower_eq_flag == (lower_result == $past(cmp_lo)))
      else $error("equality flags wrong");
   AST_GT: assert property (s_valid_op |=> upper_gt_flag == (upper_result > $past(cmp_hi))
      && lower_gt_flag == (lower_result > $past(cmp_lo)))
      else $error("magnitude flags wrong");
   AST_HOLD: assert property (op_sel > `MCRU_OP_RV_PC |=> $stable({upper_result, lower_result}))
      else $error("result moved on a non-result code");
   AST_UMUL: assert property (op_sel == `MCRU_OP_UMUL |=> {upper_result, lower_result} == $past(opa_q) * $past(opb_q))
      else $error("unsigned product wrong");
   AST_SMUL: assert property (op_sel == `MCRU_OP_SMUL |=> {upper_result, lower_result} == $past(prod_s))
      else $error("signed product wrong");
   AST_BYTE: assert property (op_sel == `MCRU_OP_HM_UL_LU |=> upper_result == $past(mul_ul)
      && lower_result == $past(mul_lu))
      else $error("byte products wrong");
   AST_COUNT: assert property (op_sel == `MCRU_OP_PC_SC |=> upper_result == $past(ones_a)
      && lower_result == $past(lead_b))
      else $error("counts wrong");
   AST_MIRROR: assert property (op_sel == `MCRU_OP_RV_PASS |=> upper_result == $past(mir_a)
      && lower_result == $past(opb_q))
      else $error("mirror or pass wrong");
endmodule // mcru_props

bind mcru_unit mcru_props u_props (.hclk, .hresetn, .crossbar_in_first, .crossbar_in_second, .clock_a_bit,
   .clock_b_bit, .op_sel, .upper_result, .lower_result, .upper_eq_flag, .lower_eq_flag, .upper_gt_flag,
   .lower_gt_flag, .upper_msb_flag, .lower_msb_flag, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready);

// ---- tb/mcru_xbar_model.sv ----
// =====================================
// crossbar and microinstruction control
module mcru_xbar_model
(
   // clock
   input wire hclk,
   // to the unit
   output logic [15:0] crossbar_in_first = 16'h0000,
   output logic [15:0] crossbar_in_second = 16'h0000,
   output logic clock_a_bit = 1'b0,
   output logic clock_b_bit = 1'b0,
   output logic [4:0] op_sel = 5'h12
);
   timeunit 1ns;
   timeprecision 1ns;
   // one opcode per cycle; lines not captured show garbage
   task automatic step(input logic [4:0] op, input logic [15:0] a, b, input logic la, lb);
      @(posedge hclk);
      op_sel <= op;
      clock_a_bit <= la;
      clock_b_bit <= lb;
      crossbar_in_first <= la ? a : ~crossbar_in_first;
      crossbar_in_second <= lb ? b : ~crossbar_in_second;
   endtask
endmodule // mcru_xbar_model

// ---- tb/tb_top.sv ----
`include "mcru_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [4:0] HOLD = 5'h12;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0;
   wire [15:0] xa, xb, up, lo;
   wire ca, cb, ueq, leq, ugt, lgt, upm, lom, hrdy, hresp;
   wire [4:0] op;
   wire [31:0] hrdata;
   int num_errors = 0, check_count = 0, cyc = 0;
   always #50 hclk = ~hclk;
   mcru_xbar_model xm (.hclk(hclk), .crossbar_in_first(xa), .crossbar_in_second(xb), .clock_a_bit(ca),
      .clock_b_bit(cb), .op_sel(op));
   mcru_unit u_dut (.hclk(hclk), .hresetn(hresetn), .crossbar_in_first(xa), .crossbar_in_second(xb),
      .clock_a_bit(ca), .clock_b_bit(cb), .op_sel(op), .upper_result(up), .lower_result(lo),
      .upper_eq_flag(ueq), .lower_eq_flag(leq), .upper_gt_flag(ugt), .lower_gt_flag(lgt),
      .upper_msb_flag(upm), .lower_msb_flag(lom), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata));
   // =====================================
   // reference arithmetic
   function automatic [15:0] m8(input [7:0] x, y);
      m8 = x * y;
   endfunction
   function automatic [15:0] ones_cnt(input [15:0] w);
      ones_cnt = 16'($countones(w));
   endfunction
   function automatic [15:0] mirror(input [15:0] w);
      mirror = {<<{w}};
   endfunction
   function automatic [15:0] lead_idx(input [15:0] w);
      lead_idx = 16'h0010;
      for (int i = 0; i < 16; i++)
         if (w[i]) lead_idx = 16'(i);
   endfunction
   function automatic [31:0] expv(input [4:0] o, input [15:0] a, b);
      logic signed [31:0] s;
      s = $signed(a) * $signed(b);
      case (o)
         `MCRU_OP_PASS: expv = {a, b};
         `MCRU_OP_SMUL: expv = s;
         `MCRU_OP_UMUL: expv = a * b;
         `MCRU_OP_HM_UU_LL: expv = {m8(a[15:8], b[15:8]), m8(a[7:0], b[7:0])};
         `MCRU_OP_HM_UL_LU: expv = {m8(a[15:8], b[7:0]), m8(a[7:0], b[15:8])};
         `MCRU_OP_HM_LU_UL: expv = {m8(a[7:0], b[15:8]), m8(a[15:8], b[7:0])};
         `MCRU_OP_HM_LL_UU: expv = {m8(a[7:0], b[7:0]), m8(a[15:8], b[15:8])};
         `MCRU_OP_PC_PC: expv = {ones_cnt(a), ones_cnt(b)};
         `MCRU_OP_RV_SC: expv = {mirror(a), lead_idx(b)};
         `MCRU_OP_PC_PASS: expv = {ones_cnt(a), b};
         `MCRU_OP_PC_SC: expv = {ones_cnt(a), lead_idx(b)};
         `MCRU_OP_PASS_PC: expv = {a, ones_cnt(b)};
         `MCRU_OP_PASS_SC: expv = {a, lead_idx(b)};
         `MCRU_OP_RV_PASS: expv = {mirror(a), b};
         default: expv = {mirror(a), ones_cnt(b)};
      endcase
   endfunction
   // =====================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic run(input logic [4:0] o, input logic [15:0] a, b);
      xm.step(HOLD, a, b, 1'b1, 1'b1);
      xm.step(o, a, b, 1'b0, 1'b0);
      xm.step(HOLD, a, b, 1'b0, 1'b0);
      #1;
   endtask
   task automatic cmpop(input logic [4:0] o, input logic [15:0] a, b, input logic la, lb, input logic [3:0] e);
      xm.step(o, a, b, la, lb);
      xm.step(`MCRU_OP_PASS, a, b, 1'b0, 1'b0);
      xm.step(HOLD, a, b, 1'b0, 1'b0);
      #1;
      chk("flags", {28'h0, e}, {28'h0, ueq, leq, ugt, lgt});
   endtask
   // =====================================
   // scenarios
   task automatic t_ops;
      logic [15:0] ta [3] = '{16'hC305, 16'hFFFD, 16'h8001};
      logic [15:0] tb [3] = '{16'h8A61, 16'h0000, 16'hFFFF};
      logic [31:0] e;
      for (int k = 0; k < 3; k++)
         for (int o = 0; o <= 14; o++)
         begin
            run(5'(o), ta[k], tb[k]);
            e = expv(5'(o), ta[k], tb[k]);
            chk("result", e, {up, lo});
            chk("msb", {30'h0, e[31], e[15]}, {30'h0, upm, lom});
         end
      $display("done ops");
   endtask
   task automatic t_pipe;
      xm.step(HOLD, 16'h0103, 16'h0205, 1'b1, 1'b1);
      xm.step(`MCRU_OP_UMUL, 16'hF00F, 16'h1234, 1'b1, 1'b1);
      xm.step(`MCRU_OP_UMUL, 16'h0, 16'h0, 1'b0, 1'b0);
      #1;
      chk("pipe1", 32'h0103 * 32'h0205, {up, lo});
      xm.step(HOLD, 16'h0, 16'h0, 1'b0, 1'b0);
      #1;
      chk("pipe2", 32'hF00F * 32'h1234, {up, lo});
      xm.step(HOLD, 16'h1111, 16'h2222, 1'b1, 1'b1);
      xm.step(HOLD, 16'h3333, 16'h0, 1'b1, 1'b0);
      xm.step(`MCRU_OP_PASS, 16'h0, 16'h0, 1'b0, 1'b0);
      xm.step(HOLD, 16'h0, 16'h0, 1'b0, 1'b0);
      #1;
      chk("latch_b", 32'h3333_2222, {up, lo});
      xm.step(HOLD, 16'h0, 16'h5555, 1'b0, 1'b1);
      xm.step(`MCRU_OP_PASS, 16'h0, 16'h0, 1'b0, 1'b0);
      xm.step(HOLD, 16'h0, 16'h0, 1'b0, 1'b0);
      #1;
      chk("latch_a", 32'h3333_5555, {up, lo});
      $display("done pipe");
   endtask
   task automatic t_cmp;
      cmpop(`MCRU_OP_LOAD_CLCH, 16'h1234, 16'h5678, 1'b1, 1'b1, 4'b1100);
      bus(1'b1, 32'h8, 32'h1233_5679);
      cmpop(HOLD, 16'h0, 16'h0, 1'b0, 1'b0, 4'b0010);
      bus(1'b0, 32'h8, 32'h0);
      chk("compare", 32'h1233_5679, rd);
      bus(1'b0, 32'h0, 32'h0);
      chk("status", 32'h0000_0004, rd);
      bus(1'b0, 32'h4, 32'h0);
      chk("resultreg", 32'h1234_5678, rd);
      bus(1'b0, 32'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      cmpop(`MCRU_OP_LOAD_CH, 16'h1234, 16'h0, 1'b1, 1'b0, 4'b1000);
      cmpop(`MCRU_OP_LOAD_CL, 16'h0, 16'h5678, 1'b0, 1'b1, 4'b1100);
      $display("done cmp");
   endtask
   // =====================================
   // closing and sequence
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         test_done;
      end
   end
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk("reset", 32'h0, {up, lo});
      chk("ready", 32'h2, {30'h0, hrdy, hresp});
      t_ops;
      t_pipe;
      t_cmp;
      test_done;
   end
endmodule // tb_top
